//--- hw/csr_consts.svh
// constants for the card suspend/resume command handler
`ifndef CSR_CONSTS_SVH
`define CSR_CONSTS_SVH
`define CSR_P1_OP_BIT 0
`define CSR_P1_SUSPEND 8'h00
`define CSR_P1_RESUME 8'h01
`define CSR_P2_ZERO 8'h00
`define CSR_LC_SUSPEND 8'h04
`define CSR_LE_SUSPEND 8'h0A
`define CSR_LC_RESUME 8'h08
`define CSR_SEL_P1_BY_NAME 8'h04
`define CSR_SW_OK 16'h9000
`define CSR_SW_COND 16'h6985
`define CSR_SW_TOKEN 16'h6982
`define CSR_SW_DURATION 16'h9864
`define CSR_SW_PARAM 16'h6A86
`define CSR_SW_LENGTH 16'h6700
`define CSR_UNIT_SEC 8'h00
`define CSR_UNIT_MIN 8'h01
`define CSR_UNIT_HOUR 8'h02
`define CSR_UNIT_DAY 8'h03
`define CSR_UNIT_TENDAY 8'h04
`define CSR_SEC_PER_MIN 32'd60
`define CSR_SEC_PER_HOUR 32'd3600
`define CSR_SEC_PER_DAY 32'd86400
`define CSR_SEC_PER_TENDAY 32'd864000
`define CSR_LFSR_SEED 64'h5A5A_C3C3_0F0F_9669
`define CSR_LFSR_TAPS 64'hD800_0000_0000_0000
`endif

//--- hw/csr_pkg.sv
// types for the card suspend/resume command handler
package csr_pkg;
	typedef enum logic [2:0] {
		CSR_CMD_SUSPEND,
		CSR_CMD_SELECT,
		CSR_CMD_READ_BINARY,
		CSR_CMD_READ_RECORD,
		CSR_CMD_TERM_CAP,
		CSR_CMD_OTHER
	} csr_cmd_t;
	typedef enum logic [1:0] {
		CSR_ST_IDLE,
		CSR_ST_COMMIT,
		CSR_ST_RESTORE
	} csr_state_t;
endpackage

//--- hw/csr_token_gen.sv
// free-running 64-bit lfsr that supplies resume tokens
`timescale 1ns/100ps
`include "csr_consts.svh"
module csr_token_gen #(
	parameter int WIDTH = 64
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// entropy mixed in every cycle
	input wire logic entropy_i,
	// current token value
	output logic [WIDTH-1:0] token_o
);
	import csr_pkg::*;
	logic [WIDTH-1:0] lfsr_ff;
	logic [WIDTH-1:0] nxt_lfsr;
	always_comb begin
		nxt_lfsr = {lfsr_ff[WIDTH-2:0], (^(lfsr_ff & WIDTH'(`CSR_LFSR_TAPS))) ^ entropy_i};
		// lock-up of all zeros is escaped by reseeding
		if (lfsr_ff == '0) begin
			nxt_lfsr = WIDTH'(`CSR_LFSR_SEED);
		end
	end
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			lfsr_ff <= WIDTH'(`CSR_LFSR_SEED);
		end else begin
			lfsr_ff <= nxt_lfsr;
		end
	end
	assign token_o = lfsr_ff;
endmodule

//--- hw/csr_suspend_resume.sv
// suspend/resume command handler: parses commands, saves and restores card state
`timescale 1ns/100ps
`include "csr_consts.svh"
module csr_suspend_resume #(
	parameter int STATE_W = 64,
	parameter int TOKEN_W = 64
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// decoded command from the apdu layer
	input wire logic cmd_valid_i,
	input wire csr_pkg::csr_cmd_t cmd_kind_i,
	input wire logic [7:0] cmd_p1_i,
	input wire logic [7:0] cmd_p2_i,
	input wire logic [7:0] cmd_lc_i,
	input wire logic [7:0] cmd_le_i,
	input wire logic cmd_le_present_i,
	input wire logic [63:0] cmd_data_i,
	// session conditions
	input wire logic proactive_active_i,
	input wire logic channel_open_i,
	input wire logic secure_channel_i,
	input wire logic internal_refuse_i,
	input wire logic [15:0] card_max_dur_i,
	input wire logic [STATE_W-1:0] live_state_i,
	// non-volatile store handshake
	output logic nvm_write_o,
	output logic [STATE_W-1:0] nvm_state_o,
	output logic [TOKEN_W-1:0] nvm_token_o,
	input wire logic nvm_done_i,
	// state restore to the card
	output logic restore_o,
	output logic [STATE_W-1:0] restore_state_o,
	output logic discard_pre_resume_o,
	// answer
	output logic rsp_valid_o,
	output logic [15:0] rsp_sw_o,
	output logic [79:0] rsp_data_o,
	output logic rsp_has_data_o,
	output logic saved_valid_o
);
	import csr_pkg::*;

	// duration in seconds for comparisons between units
	function automatic logic [31:0] dur_secs(input logic [15:0] dur);
		logic [31:0] cnt;
		cnt = {24'h000000, dur[7:0]};
		unique case (dur[15:8])
			`CSR_UNIT_SEC: dur_secs = cnt;
			`CSR_UNIT_MIN: dur_secs = cnt * `CSR_SEC_PER_MIN;
			`CSR_UNIT_HOUR: dur_secs = cnt * `CSR_SEC_PER_HOUR;
			`CSR_UNIT_DAY: dur_secs = cnt * `CSR_SEC_PER_DAY;
			`CSR_UNIT_TENDAY: dur_secs = cnt * `CSR_SEC_PER_TENDAY;
			default: dur_secs = 32'hFFFFFFFF;
		endcase
	endfunction

	// unit code valid
	function automatic logic unit_ok(input logic [15:0] dur);
		unit_ok = dur[15:8] <= `CSR_UNIT_TENDAY;
	endfunction

	csr_state_t state_ff, nxt_state;
	logic saved_ff, nxt_saved;
	logic [STATE_W-1:0] store_ff, nxt_store;
	logic [TOKEN_W-1:0] tok_ff, nxt_tok;
	logic [15:0] neg_ff, nxt_neg;
	logic rsp_valid_ff, nxt_rsp_valid;
	logic [15:0] rsp_sw_ff, nxt_rsp_sw;
	logic [79:0] rsp_data_ff, nxt_rsp_data;
	logic rsp_has_data_ff, nxt_rsp_has_data;
	logic restore_ff, nxt_restore;
	logic discard_ff, nxt_discard;
	logic [TOKEN_W-1:0] rnd_token;
	logic [15:0] min_dur, max_dur;
	logic dur_over;
	logic is_suspend, is_resume, busy_refuse, fmt_susp, fmt_res, allowed_pre;

	csr_token_gen #(
		.WIDTH(TOKEN_W)
	) u_tok (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.entropy_i(cmd_valid_i ^ cmd_data_i[0]),
		.token_o(rnd_token)
	);

	assign min_dur = cmd_data_i[63:48];
	assign max_dur = cmd_data_i[47:32];
	assign is_suspend = cmd_valid_i && cmd_kind_i == CSR_CMD_SUSPEND
		&& cmd_p1_i[`CSR_P1_OP_BIT] == 1'b0;
	assign is_resume = cmd_valid_i && cmd_kind_i == CSR_CMD_SUSPEND
		&& cmd_p1_i[`CSR_P1_OP_BIT] == 1'b1;
	assign fmt_susp = cmd_p1_i == `CSR_P1_SUSPEND && cmd_p2_i == `CSR_P2_ZERO
		&& cmd_lc_i == `CSR_LC_SUSPEND && cmd_le_present_i
		&& cmd_le_i == `CSR_LE_SUSPEND;
	assign fmt_res = cmd_p1_i == `CSR_P1_RESUME && cmd_p2_i == `CSR_P2_ZERO
		&& cmd_lc_i == `CSR_LC_RESUME && !cmd_le_present_i;
	assign busy_refuse = proactive_active_i || channel_open_i || secure_channel_i
		|| internal_refuse_i;
	assign dur_over = dur_secs(min_dur) > dur_secs(card_max_dur_i);
	// commands tolerated while a saved state waits for resume
	assign allowed_pre = (cmd_kind_i == CSR_CMD_SELECT && cmd_p1_i != `CSR_SEL_P1_BY_NAME)
		|| cmd_kind_i == CSR_CMD_READ_BINARY || cmd_kind_i == CSR_CMD_READ_RECORD
		|| cmd_kind_i == CSR_CMD_TERM_CAP;

	always_comb begin
		nxt_state = state_ff;
		nxt_saved = saved_ff;
		nxt_store = store_ff;
		nxt_tok = tok_ff;
		nxt_neg = neg_ff;
		nxt_rsp_valid = 1'b0;
		nxt_rsp_sw = rsp_sw_ff;
		nxt_rsp_data = rsp_data_ff;
		nxt_rsp_has_data = rsp_has_data_ff;
		nxt_restore = 1'b0;
		nxt_discard = 1'b0;
		unique case (state_ff)
			CSR_ST_IDLE: begin
				if (is_suspend) begin
					nxt_rsp_has_data = 1'b0;
					nxt_rsp_data = '0;
					if (!fmt_susp) begin
						nxt_rsp_valid = 1'b1;
						nxt_rsp_sw = (cmd_lc_i != `CSR_LC_SUSPEND) ? `CSR_SW_LENGTH
							: `CSR_SW_PARAM;
					end else if (busy_refuse) begin
						nxt_rsp_valid = 1'b1;
						nxt_rsp_sw = `CSR_SW_COND;
					end else if (!unit_ok(min_dur) || !unit_ok(max_dur)
						|| dur_secs(min_dur) > dur_secs(max_dur)) begin
						nxt_rsp_valid = 1'b1;
						nxt_rsp_sw = `CSR_SW_PARAM;
					end else if (dur_over) begin
						nxt_rsp_valid = 1'b1;
						nxt_rsp_sw = `CSR_SW_DURATION;
					end else begin
						// clamp card limit into the proposed window
						if (dur_secs(card_max_dur_i) >= dur_secs(max_dur)) begin
							nxt_neg = max_dur;
						end else begin
							nxt_neg = card_max_dur_i;
						end
						nxt_store = live_state_i;
						nxt_tok = rnd_token;
						nxt_saved = 1'b0;
						nxt_state = CSR_ST_COMMIT;
					end
				end else if (is_resume) begin
					nxt_rsp_valid = 1'b1;
					nxt_rsp_has_data = 1'b0;
					nxt_rsp_data = '0;
					if (!fmt_res) begin
						nxt_rsp_sw = (cmd_lc_i != `CSR_LC_RESUME) ? `CSR_SW_LENGTH
							: `CSR_SW_PARAM;
						nxt_saved = 1'b0;
					end else if (!saved_ff) begin
						nxt_rsp_sw = `CSR_SW_COND;
					end else if (cmd_data_i != tok_ff) begin
						nxt_rsp_sw = `CSR_SW_TOKEN;
						nxt_saved = 1'b0;
					end else begin
						nxt_rsp_sw = `CSR_SW_OK;
						nxt_restore = 1'b1;
						nxt_discard = 1'b1;
						nxt_saved = 1'b0;
					end
				end else if (cmd_valid_i && saved_ff && !allowed_pre) begin
					nxt_saved = 1'b0;
				end
			end
			CSR_ST_COMMIT: begin
				// answer only once storage holds state and token
				if (nvm_done_i) begin
					nxt_saved = 1'b1;
					nxt_rsp_valid = 1'b1;
					nxt_rsp_sw = `CSR_SW_OK;
					nxt_rsp_data = {neg_ff, tok_ff};
					nxt_rsp_has_data = 1'b1;
					nxt_state = CSR_ST_IDLE;
				end
			end
			CSR_ST_RESTORE: begin
				nxt_state = CSR_ST_IDLE;
			end
			default: begin
				nxt_state = CSR_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_ff <= CSR_ST_IDLE;
			saved_ff <= 1'b0;
			store_ff <= '0;
			tok_ff <= '0;
			neg_ff <= 16'h0000;
			rsp_valid_ff <= 1'b0;
			rsp_sw_ff <= 16'h0000;
			rsp_data_ff <= '0;
			rsp_has_data_ff <= 1'b0;
			restore_ff <= 1'b0;
			discard_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			saved_ff <= nxt_saved;
			store_ff <= nxt_store;
			tok_ff <= nxt_tok;
			neg_ff <= nxt_neg;
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_sw_ff <= nxt_rsp_sw;
			rsp_data_ff <= nxt_rsp_data;
			rsp_has_data_ff <= nxt_rsp_has_data;
			restore_ff <= nxt_restore;
			discard_ff <= nxt_discard;
		end
	end

	assign nvm_write_o = state_ff == CSR_ST_COMMIT;
	assign nvm_state_o = store_ff;
	assign nvm_token_o = tok_ff;
	assign restore_o = restore_ff;
	assign restore_state_o = store_ff;
	assign discard_pre_resume_o = discard_ff;
	assign rsp_valid_o = rsp_valid_ff;
	assign rsp_sw_o = rsp_sw_ff;
	assign rsp_data_o = rsp_data_ff;
	assign rsp_has_data_o = rsp_has_data_ff;
	assign saved_valid_o = saved_ff;

	// helper: commit ends in an ok answer carrying the token
	sequence s_commit_done;
		state_ff == CSR_ST_COMMIT && nvm_done_i;
	endsequence
	sequence s_ok_answer;
		rsp_valid_o && rsp_sw_o == `CSR_SW_OK && rsp_data_o[63:0] == nvm_token_o;
	endsequence
	// a suspend that passed every refusal and starts its commit
	sequence s_suspend_taken;
		state_ff == CSR_ST_IDLE && is_suspend && nxt_state == CSR_ST_COMMIT;
	endsequence

	// suspend refusals
	a_busy_refuse: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_ff == CSR_ST_IDLE && is_suspend && fmt_susp && busy_refuse
		|=> rsp_valid_o && rsp_sw_o == `CSR_SW_COND && state_ff == CSR_ST_IDLE)
		else $error("busy suspend not refused with 6985");
	a_dur_refuse: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		rsp_valid_o && rsp_sw_o == `CSR_SW_DURATION |-> $past(dur_over))
		else $error("9864 without oversize minimum");
	a_fmt_refuse: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_ff == CSR_ST_IDLE && is_suspend && !fmt_susp
		|=> rsp_valid_o && !nvm_write_o
		&& (rsp_sw_o == `CSR_SW_LENGTH || rsp_sw_o == `CSR_SW_PARAM))
		else $error("malformed suspend not refused");
	a_unit_refuse: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_ff == CSR_ST_IDLE && is_suspend && fmt_susp && !busy_refuse
		&& (!unit_ok(min_dur) || !unit_ok(max_dur))
		|=> rsp_valid_o && rsp_sw_o == `CSR_SW_PARAM)
		else $error("unknown time unit accepted");

	// commit and answer
	a_commit_write: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		s_suspend_taken |=> nvm_write_o && !rsp_valid_o && !saved_valid_o)
		else $error("accepted suspend did not start commit");
	a_commit_wait: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_ff == CSR_ST_COMMIT && !nvm_done_i |=> state_ff == CSR_ST_COMMIT)
		else $error("commit left before storage done");
	a_commit_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		nvm_write_o |=> $stable(nvm_state_o) && $stable(nvm_token_o))
		else $error("saved image moved during commit");
	a_commit_answer: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		s_commit_done |=> s_ok_answer and saved_valid_o)
		else $error("suspend answer lacks token or ok");
	a_no_early_ok: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_ff == CSR_ST_COMMIT && !nvm_done_i |=> !rsp_valid_o)
		else $error("answer before storage commit");
	a_no_pending: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		rsp_valid_o && rsp_has_data_o |-> rsp_sw_o == `CSR_SW_OK && saved_valid_o)
		else $error("suspend answer not plain 9000");
	a_neg_window: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		s_suspend_taken
		|=> dur_secs(neg_ff) <= dur_secs($past(max_dur))
		&& dur_secs(neg_ff) >= dur_secs($past(min_dur)))
		else $error("negotiated duration outside window");

	// resume and pre-resume commands
	a_resume_erase: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_ff == CSR_ST_IDLE && is_resume |=> !saved_valid_o)
		else $error("saved state kept after resume");
	a_res_format: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_ff == CSR_ST_IDLE && is_resume && !fmt_res
		|=> rsp_valid_o && !restore_o && rsp_sw_o != `CSR_SW_OK)
		else $error("malformed resume not refused");
	a_no_state: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_ff == CSR_ST_IDLE && is_resume && fmt_res && !saved_ff
		|=> rsp_sw_o == `CSR_SW_COND && !restore_o)
		else $error("resume without state not refused");
	a_token_check: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_ff == CSR_ST_IDLE && is_resume && fmt_res && saved_ff
		|=> (restore_o == ($past(cmd_data_i) == $past(tok_ff)))
		&& rsp_sw_o == (restore_o ? `CSR_SW_OK : `CSR_SW_TOKEN))
		else $error("token compare answer wrong");
	a_restore_pair: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		restore_o |-> discard_pre_resume_o && rsp_valid_o && rsp_sw_o == `CSR_SW_OK)
		else $error("restore without discard and ok");
	a_restore_once: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		restore_o |=> !restore_o)
		else $error("restore pulse longer than one cycle");
	a_foreign_erase: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_ff == CSR_ST_IDLE && cmd_valid_i && cmd_kind_i == CSR_CMD_OTHER
		|=> !saved_valid_o)
		else $error("foreign command kept saved state");
	a_pre_keep: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_ff == CSR_ST_IDLE && cmd_valid_i && saved_ff && allowed_pre
		|=> saved_valid_o)
		else $error("permitted command erased saved state");
	a_saved_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_ff == CSR_ST_IDLE && saved_ff && !cmd_valid_i |=> saved_valid_o)
		else $error("saved state lost without a command");
endmodule

//--- verification/csr_nvm_model.sv
// non-volatile store model: answers a commit request after a set delay
`timescale 1ns/100ps
module csr_nvm_model (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// commit handshake
	input wire logic nvm_write_i,
	input wire logic [3:0] delay_i,
	output logic nvm_done_o
);
	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic done_ff;
	logic nxt_done;
	// done only once the whole commit time has passed
	always_comb begin
		nxt_done = nvm_write_i && !done_ff && cnt_ff == delay_i;
		nxt_cnt = (nvm_write_i && !done_ff) ? cnt_ff + 4'h1 : 4'h0;
	end
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_ff <= 4'h0;
			done_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end
	assign nvm_done_o = done_ff;
endmodule

//--- verification/card_suspend_resume_test.sv
// self-checking bench for the suspend/resume command handler
`timescale 1ns/100ps
`include "csr_consts.svh"
module card_suspend_resume_test;
	import csr_pkg::*;
	typedef struct {
		logic [7:0] p1;
		logic [7:0] lc;
		logic [3:0] busy;
		logic [15:0] cmax;
		logic [31:0] dur;
		logic [15:0] sw;
		logic [15:0] neg;
	} csr_row_t;
	csr_row_t rows[12] = '{
		'{8'h00, 8'h04, 4'h8, 16'h030A, 32'h001E_0105, 16'h6985, 16'h0},
		'{8'h00, 8'h04, 4'h4, 16'h030A, 32'h001E_0105, 16'h6985, 16'h0},
		'{8'h00, 8'h04, 4'h2, 16'h030A, 32'h001E_0105, 16'h6985, 16'h0},
		'{8'h00, 8'h04, 4'h1, 16'h030A, 32'h001E_0105, 16'h6985, 16'h0},
		'{8'h00, 8'h04, 4'h0, 16'h0201, 32'h0301_0302, 16'h9864, 16'h0},
		'{8'h01, 8'h08, 4'h0, 16'h030A, 32'h0, 16'h6985, 16'h0},
		'{8'h00, 8'h03, 4'h0, 16'h030A, 32'h001E_0105, 16'h6700, 16'h0},
		'{8'h00, 8'h04, 4'h0, 16'h030A, 32'h0501_0105, 16'h6A86, 16'h0},
		'{8'h00, 8'h04, 4'h0, 16'h030A, 32'h0105_001E, 16'h6A86, 16'h0},
		'{8'h00, 8'h04, 4'h0, 16'h030A, 32'h001E_0105, 16'h9000, 16'h0105},
		'{8'h00, 8'h04, 4'h0, 16'h0102, 32'h001E_0201, 16'h9000, 16'h0102},
		'{8'h00, 8'h04, 4'h0, 16'h0402, 32'h0301_0403, 16'h9000, 16'h0402}};
	logic sys_clk_i, reset_i, cmd_valid, lep, pro, chn, sec, intr, rst_seen, dsc_seen;
	csr_cmd_t kind;
	logic [7:0] p1, p2, lc, le;
	logic [15:0] cmax;
	logic [63:0] data, live, tok, prev;
	logic [3:0] dly;
	logic nvm_write, nvm_done, restore, discard, rsp_valid, has_data, saved;
	logic [63:0] nvm_state, nvm_token, restore_state;
	logic [15:0] sw;
	logic [79:0] rdata;
	int err_count = 0;
	int check_count = 0;
	int lat;
	csr_suspend_resume i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid),
		.cmd_kind_i(kind), .cmd_p1_i(p1), .cmd_p2_i(p2), .cmd_lc_i(lc), .cmd_le_i(le),
		.cmd_le_present_i(lep), .cmd_data_i(data), .proactive_active_i(pro),
		.channel_open_i(chn), .secure_channel_i(sec), .internal_refuse_i(intr),
		.card_max_dur_i(cmax), .live_state_i(live), .nvm_write_o(nvm_write),
		.nvm_state_o(nvm_state), .nvm_token_o(nvm_token), .nvm_done_i(nvm_done),
		.restore_o(restore), .restore_state_o(restore_state), .discard_pre_resume_o(discard),
		.rsp_valid_o(rsp_valid), .rsp_sw_o(sw), .rsp_data_o(rdata), .rsp_has_data_o(has_data),
		.saved_valid_o(saved));
	csr_nvm_model i_nvm (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .nvm_write_i(nvm_write),
		.delay_i(dly), .nvm_done_o(nvm_done));
	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	task automatic chk(logic [79:0] got, logic [79:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(logic got, logic exp);
		chk({79'h0, got}, {79'h0, exp});
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// one command pulse; optionally wait for the answer and catch the restore pulses
	task automatic send(csr_cmd_t k, logic [7:0] a, logic [7:0] l, logic [63:0] d, bit w);
		@(posedge sys_clk_i);
		cmd_valid <= 1'b1;
		kind <= k;
		p1 <= a;
		lc <= l;
		lep <= !a[0];
		data <= d;
		@(posedge sys_clk_i);
		cmd_valid <= 1'b0;
		rst_seen = 1'b0;
		for (lat = 0; w && lat < 60; lat++) begin
			#1;
			if (rsp_valid === 1'b1) begin
				rst_seen = restore;
				dsc_seen = discard;
				break;
			end
			@(posedge sys_clk_i);
		end
		if (w) chk_bit(lat < 60, 1'b1);
		else repeat (2) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic susp(logic [63:0] st);
		live <= st;
		send(CSR_CMD_SUSPEND, 8'h00, 8'h04, {32'h001E_0105, 32'h0}, 1);
		chk(sw, `CSR_SW_OK);
		tok = rdata[63:0];
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		err_count++;
		conclude();
	end
	initial begin
		reset_i <= 1'b1;
		{cmd_valid, lep, pro, chn, sec, intr} <= '0;
		kind <= CSR_CMD_OTHER;
		{p1, p2, lc, data, cmax, live, dly} <= '0;
		le <= `CSR_LE_SUSPEND;
		prev = '0;
		repeat (3) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		#1;
		chk_bit(saved | rsp_valid | nvm_write, 1'b0);
		// bench terminal: capability advertised, contact interface only
		foreach (rows[i]) begin
			{pro, chn, sec, intr} <= rows[i].busy;
			cmax <= rows[i].cmax;
			live <= 64'hA5A5_0000_0000_0000 | i;
			dly <= 4'h3;
			send(CSR_CMD_SUSPEND, rows[i].p1, rows[i].lc, {rows[i].dur, 32'h0}, 1);
			chk(sw, rows[i].sw);
			chk_bit(has_data, rows[i].sw == `CSR_SW_OK);
			if (rows[i].sw == `CSR_SW_OK) begin
				chk(rdata[79:64], rows[i].neg);
				chk(nvm_token, rdata[63:0]);
				chk_bit(rdata[63:0] !== prev, 1'b1);
				chk(nvm_state, 64'hA5A5_0000_0000_0000 | i);
				chk_bit(saved, 1'b1);
				chk_bit(lat > 3, 1'b1);
				prev = rdata[63:0];
			end
			$display("row %0d done", i);
		end
		send(CSR_CMD_TERM_CAP, 8'h00, 8'h02, 64'h0, 0);
		send(CSR_CMD_SELECT, 8'h00, 8'h02, 64'h0, 0);
		send(CSR_CMD_READ_BINARY, 8'h00, 8'h00, 64'h0, 0);
		send(CSR_CMD_READ_RECORD, 8'h00, 8'h00, 64'h0, 0);
		chk_bit(saved, 1'b1);
		send(CSR_CMD_SUSPEND, 8'h01, 8'h08, ~prev, 1);
		chk(sw, `CSR_SW_TOKEN);
		chk_bit(saved, 1'b0);
		$display("wrong token test done");
		cmax <= 16'h030A;
		susp(64'h1234_5678_9ABC_DEF0);
		live <= 64'h0;
		send(CSR_CMD_SUSPEND, 8'h01, 8'h08, tok, 1);
		chk(sw, `CSR_SW_OK);
		chk({rst_seen, dsc_seen}, 2'h3);
		chk(restore_state, 64'h1234_5678_9ABC_DEF0);
		chk_bit(saved, 1'b0);
		send(CSR_CMD_SUSPEND, 8'h01, 8'h08, tok, 1);
		chk(sw, `CSR_SW_COND);
		$display("resume test done");
		for (int j = 0; j < 2; j++) begin
			susp(64'h0F0F);
			send(j ? CSR_CMD_OTHER : CSR_CMD_SELECT, 8'h04, 8'h02, 64'h0, 0);
			chk_bit(saved, 1'b0);
			send(CSR_CMD_SUSPEND, 8'h01, 8'h08, tok, 1);
			chk(sw, `CSR_SW_COND);
		end
		$display("erase test done");
		susp(64'h00FF);
		send(CSR_CMD_SUSPEND, 8'h03, 8'h08, tok, 1);
		chk(sw, `CSR_SW_PARAM);
		$display("upper bits test done");
		p2 <= 8'h01;
		send(CSR_CMD_SUSPEND, 8'h00, 8'h04, {32'h001E_0105, 32'h0}, 1);
		chk(sw, `CSR_SW_PARAM);
		send(CSR_CMD_SUSPEND, 8'h01, 8'h08, tok, 1);
		chk(sw, `CSR_SW_PARAM);
		p2 <= 8'h00;
		le <= 8'h09;
		send(CSR_CMD_SUSPEND, 8'h00, 8'h04, {32'h001E_0105, 32'h0}, 1);
		chk(sw, `CSR_SW_PARAM);
		le <= `CSR_LE_SUSPEND;
		$display("header test done");
		susp(64'h00FF);
		// contacts dropped after the suspend answer
		reset_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk_bit(saved | rsp_valid | nvm_write, 1'b0);
		$display("reset test done");
		conclude();
	end
endmodule
